// [rtl/tpm_map.svh]
// Purpose: offsets, field positions, limits and timing of the performance monitor
// Assumes: included by the package user only
// Notes:   register offsets are word indices; byte address is four times the index
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH
// ----------------------------------------
// register word indices
// ----------------------------------------
`define TPM_IDX_PORT    14'h000e
`define TPM_IDX_DATA    14'h000f
`define TPM_OFF_CTRL    8'hc2
`define TPM_OFF_EN_LO   8'hc3
`define TPM_OFF_EN_HI   8'hc4
`define TPM_OFF_FLG_LO  8'hc5
`define TPM_OFF_FLG_HI  8'hc6
// ----------------------------------------
// field positions
// ----------------------------------------
`define TPM_PORT_CNT    3:0
`define TPM_PORT_LINK   6:4
`define TPM_CTRL_TRIG   0
`define TPM_CTRL_AUTO   1
`define TPM_CTRL_FMT    3:2
`define TPM_CTRL_B8ZS   4
// ----------------------------------------
// counter slots and their limits
// ----------------------------------------
`define TPM_C_LCV   0
`define TPM_C_FER   1
`define TPM_C_CRC   2
`define TPM_C_DDS   3
`define TPM_C_COFA  4
`define TPM_C_OOF   5
`define TPM_C_PATTERN_CHECKER  6
`define TPM_MAX_LCV   16'hffff
`define TPM_MAX_FER   16'h0fff
`define TPM_MAX_CRC   16'h03ff
`define TPM_MAX_DDS   16'h03ff
`define TPM_MAX_COFA  16'h0007
`define TPM_MAX_OOF   16'h001f
`define TPM_MAX_PATTERN_CHECKER  16'hffff
// ----------------------------------------
// indirect counter byte indices
// ----------------------------------------
`define TPM_ID_CRC_LO   4'h0
`define TPM_ID_CRC_HI   4'h1
`define TPM_ID_FER_LO   4'h2
`define TPM_ID_FER_HI   4'h3
`define TPM_ID_COFA     4'h4
`define TPM_ID_OOF      4'h5
`define TPM_ID_PATTERN_CHECKER_LO  4'h6
`define TPM_ID_PATTERN_CHECKER_HI  4'h7
`define TPM_ID_LCV_LO   4'h8
`define TPM_ID_LCV_HI   4'h9
`define TPM_ID_DDS_LO   4'ha
`define TPM_ID_DDS_HI   4'hb
// ----------------------------------------
// timing
// ----------------------------------------
`define TPM_CLK_NS      100
`define TPM_REPORT_NS   1000000000
`define TPM_REPORT_CYC  (`TPM_REPORT_NS / `TPM_CLK_NS)
`endif

// [rtl/tpm_monitor.sv]
// Purpose: eight-link receive performance monitor with indirect counter access over apb
// Assumes: event inputs are synchronous single-cycle strobes
// Notes:   apb answers one cycle after setup; counters saturate until the next report
//
// The APB register port was left to the implementer.
`include "tpm_map.svh"

// Function
// - format decides which counters run
// - overflow sets flag; enable gates interrupt
// - link select then counter index
// - auto report each second when enabled; code acts only on the auto bit of the link selected in the port
// - trigger rising edge forces a report; code acts only on the trigger of the link selected in the port
// - report clears whole link bank
// - event during clear counts next round
// - line violations per AMI or B8ZS
// - SF counter set and widths
// - ESF counts alignment errors and CRC-6
// - alignment change on differing F position
// - count losses of frame synchronization
// - DDS format adds DDS pattern counter
// - SLC-96 uses the five basic counters
// - line violations at indices 9/8
// - framing errors at indices 3/2
// - alignment 4, sync loss 5
// - pattern errors at indices 7/6
// - CRC at 1/0, DDS at B/A
// - per-link registers every 0x100
module tpm_monitor
	import tpm_pkg::*;
#(
	parameter int REPORT_CYCLES = `TPM_REPORT_CYC
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire tpm_apb_req_t apb,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire tpm_ev_t [7:0] link_events,
	output logic              overflow_irq
);
	localparam logic [6:0][15:0] CMAX = {`TPM_MAX_PATTERN_CHECKER, `TPM_MAX_OOF, `TPM_MAX_COFA,
		`TPM_MAX_DDS, `TPM_MAX_CRC, `TPM_MAX_FER, `TPM_MAX_LCV};
	localparam logic [23:0] TICK_LAST = 24'(REPORT_CYCLES - 1);

	tpm_state_t       s_q;
	tpm_state_t       s_d;
	logic [7:0][6:0]  ev_w;
	logic [7:0]       irq_w;
	logic             tick;
	logic [2:0]       sel;
	logic             manual;
	logic             report;

	// ----------------------------------------
	// byte packing helpers
	// ----------------------------------------
	function automatic logic [7:0] pick(tpm_link_t lk, logic [3:0] i);
		case (i)
			`TPM_ID_CRC_LO:  pick = lk.cnt[`TPM_C_CRC][7:0];
			`TPM_ID_CRC_HI:  pick = lk.cnt[`TPM_C_CRC][15:8];
			`TPM_ID_FER_LO:  pick = lk.cnt[`TPM_C_FER][7:0];
			`TPM_ID_FER_HI:  pick = lk.cnt[`TPM_C_FER][15:8];
			`TPM_ID_COFA:    pick = lk.cnt[`TPM_C_COFA][7:0];
			`TPM_ID_OOF:     pick = lk.cnt[`TPM_C_OOF][7:0];
			`TPM_ID_PATTERN_CHECKER_LO: pick = lk.cnt[`TPM_C_PATTERN_CHECKER][7:0];
			`TPM_ID_PATTERN_CHECKER_HI: pick = lk.cnt[`TPM_C_PATTERN_CHECKER][15:8];
			`TPM_ID_LCV_LO:  pick = lk.cnt[`TPM_C_LCV][7:0];
			`TPM_ID_LCV_HI:  pick = lk.cnt[`TPM_C_LCV][15:8];
			`TPM_ID_DDS_LO:  pick = lk.cnt[`TPM_C_DDS][7:0];
			`TPM_ID_DDS_HI:  pick = lk.cnt[`TPM_C_DDS][15:8];
			default:         pick = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] pack_lo(logic [6:0] v);
		pack_lo = {3'h0, v[`TPM_C_DDS], v[`TPM_C_CRC], v[`TPM_C_PATTERN_CHECKER], v[`TPM_C_OOF], v[`TPM_C_COFA]};
	endfunction

	function automatic logic [7:0] pack_hi(logic [6:0] v);
		pack_hi = {6'h00, v[`TPM_C_FER], v[`TPM_C_LCV]};
	endfunction

	// ----------------------------------------
	// per-link event qualification
	// ----------------------------------------
	for (genvar l = 0; l < 8; l++) begin : g_link
		tpm_fmt_t fmt;
		assign fmt = tpm_fmt_t'(s_q.lk[l].ctrl[`TPM_CTRL_FMT]);
		// decoding mode picks the violation source
		assign ev_w[l][`TPM_C_LCV]  = s_q.lk[l].ctrl[`TPM_CTRL_B8ZS] ?
			link_events[l].b8zs_cv : link_events[l].bpv;
		assign ev_w[l][`TPM_C_FER]  = link_events[l].fbit_err;
		assign ev_w[l][`TPM_C_CRC]  = link_events[l].crc_err & (fmt == TPM_FMT_ESF);
		assign ev_w[l][`TPM_C_DDS]  = link_events[l].dds_err & (fmt == TPM_FMT_DDS);
		// only a position that differs from the last found one counts
		assign ev_w[l][`TPM_C_COFA] = link_events[l].pos_found & s_q.lk[l].pos_ok &
			(link_events[l].pos != s_q.lk[l].pos);
		assign ev_w[l][`TPM_C_OOF]  = link_events[l].sync_lost;
		assign ev_w[l][`TPM_C_PATTERN_CHECKER] = link_events[l].pat_err;
		assign irq_w[l] = |(s_q.lk[l].flag & s_q.lk[l].en);
	end

	// ----------------------------------------
	// report triggers
	// ----------------------------------------
	assign sel    = s_q.port[`TPM_PORT_LINK];
	assign tick   = (s_q.tick_cnt == TICK_LAST);
	assign manual = s_q.lk[sel].ctrl[`TPM_CTRL_TRIG] & ~s_q.lk[sel].trig_prev;
	assign report = manual | (tick & s_q.lk[sel].ctrl[`TPM_CTRL_AUTO]);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic [13:0] idx;
		logic [2:0]  pl;
		logic        pg;
		logic        clr;
		logic        full;
		idx  = apb.paddr[15:2];
		pl   = idx[10:8];
		pg   = (idx[13:11] == 3'h0);
		clr  = 1'b0;
		full = 1'b0;
		s_d  = s_q;
		// free-running one-second timebase
		s_d.tick_cnt = tick ? 24'h000000 : s_q.tick_cnt + 24'h000001;
		if (report) begin
			s_d.data = pick(s_q.lk[sel], s_q.port[`TPM_PORT_CNT]);
		end
		// apb setup: capture read data for the access phase
		if (apb.psel && !apb.penable) begin
			s_d.prdata = 32'h00000000;
			s_d.slverr = 1'b0;
			if (idx == `TPM_IDX_PORT) begin
				s_d.prdata[7:0] = s_q.port;
			end else if (idx == `TPM_IDX_DATA) begin
				s_d.prdata[7:0] = s_q.data;
			end else if (pg) begin
				case (idx[7:0])
					`TPM_OFF_CTRL:   s_d.prdata[7:0] = s_q.lk[pl].ctrl;
					`TPM_OFF_EN_LO:  s_d.prdata[7:0] = pack_lo(s_q.lk[pl].en);
					`TPM_OFF_EN_HI:  s_d.prdata[7:0] = pack_hi(s_q.lk[pl].en);
					`TPM_OFF_FLG_LO: s_d.prdata[7:0] = pack_lo(s_q.lk[pl].flag);
					`TPM_OFF_FLG_HI: s_d.prdata[7:0] = pack_hi(s_q.lk[pl].flag);
					default:         s_d.slverr = 1'b1;
				endcase
			end else begin
				s_d.slverr = 1'b1;
			end
		end
		// apb access: writes land here; flag clears come before event sets
		if (apb.psel && apb.penable && apb.pwrite) begin
			if (idx == `TPM_IDX_PORT) begin
				s_d.port = {1'b0, apb.pwdata[6:0]};
			end else if (pg) begin
				case (idx[7:0])
					`TPM_OFF_CTRL: s_d.lk[pl].ctrl = {3'h0, apb.pwdata[4:0]};
					`TPM_OFF_EN_LO: begin
						s_d.lk[pl].en[`TPM_C_COFA] = apb.pwdata[0];
						s_d.lk[pl].en[`TPM_C_OOF]  = apb.pwdata[1];
						s_d.lk[pl].en[`TPM_C_PATTERN_CHECKER] = apb.pwdata[2];
						s_d.lk[pl].en[`TPM_C_CRC]  = apb.pwdata[3];
						s_d.lk[pl].en[`TPM_C_DDS]  = apb.pwdata[4];
					end
					`TPM_OFF_EN_HI: begin
						s_d.lk[pl].en[`TPM_C_LCV] = apb.pwdata[0];
						s_d.lk[pl].en[`TPM_C_FER] = apb.pwdata[1];
					end
					`TPM_OFF_FLG_LO: begin
						if (apb.pwdata[0]) s_d.lk[pl].flag[`TPM_C_COFA] = 1'b0;
						if (apb.pwdata[1]) s_d.lk[pl].flag[`TPM_C_OOF]  = 1'b0;
						if (apb.pwdata[2]) s_d.lk[pl].flag[`TPM_C_PATTERN_CHECKER] = 1'b0;
						if (apb.pwdata[3]) s_d.lk[pl].flag[`TPM_C_CRC]  = 1'b0;
						if (apb.pwdata[4]) s_d.lk[pl].flag[`TPM_C_DDS]  = 1'b0;
					end
					`TPM_OFF_FLG_HI: begin
						if (apb.pwdata[0]) s_d.lk[pl].flag[`TPM_C_LCV] = 1'b0;
						if (apb.pwdata[1]) s_d.lk[pl].flag[`TPM_C_FER] = 1'b0;
					end
					default: ;
				endcase
			end
		end
		// counters: saturate, flag on overflow, clear on report
		for (int l = 0; l < 8; l++) begin
			s_d.lk[l].trig_prev = s_q.lk[l].ctrl[`TPM_CTRL_TRIG];
			if (link_events[l].pos_found) begin
				s_d.lk[l].pos    = link_events[l].pos;
				s_d.lk[l].pos_ok = 1'b1;
			end
			clr = report && (sel == 3'(l));
			for (int c = 0; c < 7; c++) begin
				full = (s_q.lk[l].cnt[c] == CMAX[c]);
				if (ev_w[l][c] && full) begin
					s_d.lk[l].flag[c] = 1'b1;
				end
				if (clr) begin
					s_d.lk[l].cnt[c] = {15'h0000, ev_w[l][c]};
				end else if (ev_w[l][c] && !full) begin
					s_d.lk[l].cnt[c] = s_q.lk[l].cnt[c] + 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------
	// state register and outputs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready       = apb.psel & apb.penable;
	assign prdata       = s_q.prdata;
	assign pslverr      = s_q.slverr & pready;
	assign overflow_irq = |irq_w;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_trig_rise;
		manual ##0 (s_q.port[`TPM_PORT_CNT] == `TPM_ID_COFA);
	endsequence
	property p_manual_copy;
		s_trig_rise |=> (s_q.data == 8'($past(s_q.lk[sel].cnt[`TPM_C_COFA])));
	endproperty
	a_manual_copy: assert property (p_manual_copy) else $error("manual report copied wrong byte");

	property p_clear;
		report && sel == 3'h0 && !ev_w[0][`TPM_C_LCV] |=> s_q.lk[0].cnt[`TPM_C_LCV] == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("link bank not cleared after report");

	property p_keep_event;
		report && sel == 3'h0 && ev_w[0][`TPM_C_OOF] |=> s_q.lk[0].cnt[`TPM_C_OOF] == 16'h0001;
	endproperty
	a_keep_event: assert property (p_keep_event) else $error("event lost during clear");

	property p_saturate;
		s_q.lk[0].cnt[`TPM_C_COFA] == `TPM_MAX_COFA && !report |=>
			s_q.lk[0].cnt[`TPM_C_COFA] == `TPM_MAX_COFA;
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter left its ceiling");

	property p_flag;
		ev_w[0][`TPM_C_COFA] && s_q.lk[0].cnt[`TPM_C_COFA] == `TPM_MAX_COFA |=>
			s_q.lk[0].flag[`TPM_C_COFA];
	endproperty
	a_flag: assert property (p_flag) else $error("overflow flag not set");

	property p_irq;
		overflow_irq == (|(s_q.lk[3].flag & s_q.lk[3].en) || (|irq_w[2:0]) || (|irq_w[7:4]));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt disagrees with flags");

	property p_crc_gate;
		s_q.lk[1].ctrl[`TPM_CTRL_FMT] != TPM_FMT_ESF && !report |=> $stable(s_q.lk[1].cnt[`TPM_C_CRC]);
	endproperty
	a_crc_gate: assert property (p_crc_gate) else $error("crc counted outside esf");

	property p_dds_gate;
		s_q.lk[1].ctrl[`TPM_CTRL_FMT] != TPM_FMT_DDS && !report |=> $stable(s_q.lk[1].cnt[`TPM_C_DDS]);
	endproperty
	a_dds_gate: assert property (p_dds_gate) else $error("dds counted outside dds format");

	property p_tick;
		tick |=> s_q.tick_cnt == 24'h000000 ##1 s_q.tick_cnt == 24'h000001;
	endproperty
	a_tick: assert property (p_tick) else $error("timebase did not wrap");

	property p_answer;
		apb.psel && !apb.penable ##1 apb.psel && apb.penable |-> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("apb access not answered");

	// an overflow flag stays up until software writes it clear
	property p_flag_hold;
		s_q.lk[0].flag[`TPM_C_COFA] && !(apb.psel && apb.penable && apb.pwrite) |=>
			s_q.lk[0].flag[`TPM_C_COFA];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped by itself");

	// in ami decoding a lone b8zs violation leaves the line counter still
	property p_ami_source;
		!s_q.lk[0].ctrl[`TPM_CTRL_B8ZS] && link_events[0].b8zs_cv && !link_events[0].bpv && !report |=>
			$stable(s_q.lk[0].cnt[`TPM_C_LCV]);
	endproperty
	a_ami_source: assert property (p_ami_source) else $error("line counter used wrong source");

	// the first position found after reset is only recorded
	property p_first_pos;
		link_events[0].pos_found && !s_q.lk[0].pos_ok && !report |=> $stable(s_q.lk[0].cnt[`TPM_C_COFA]);
	endproperty
	a_first_pos: assert property (p_first_pos) else $error("first position counted as a change");

	// an automatic report of the sync loss index copies that counter
	sequence s_auto_tick;
		tick && s_q.lk[sel].ctrl[`TPM_CTRL_AUTO] ##0 (s_q.port[`TPM_PORT_CNT] == `TPM_ID_OOF);
	endsequence
	property p_auto_copy;
		s_auto_tick |=> (s_q.data == 8'($past(s_q.lk[sel].cnt[`TPM_C_OOF])));
	endproperty
	a_auto_copy: assert property (p_auto_copy) else $error("auto report copied wrong byte");

	// the data byte changes only on a report
	property p_data_hold;
		!report |=> $stable(s_q.data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data byte changed without a report");

	// a trigger held high gives no second report
	sequence s_trig_held;
		s_q.lk[sel].ctrl[`TPM_CTRL_TRIG] ##0 s_q.lk[sel].trig_prev;
	endsequence
	property p_trig_level;
		s_trig_held ##0 !tick |-> !report;
	endproperty
	a_trig_level: assert property (p_trig_level) else $error("held trigger reported again");

	// the timebase steps by one between wraps
	property p_tick_step;
		!tick |=> s_q.tick_cnt == $past(s_q.tick_cnt) + 24'h000001;
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("timebase skipped a step");

	// a report on link 0 leaves the bank of link 2 alone
	property p_clear_only_sel;
		report && sel == 3'h0 |=> s_q.lk[2].cnt[`TPM_C_CRC] >= $past(s_q.lk[2].cnt[`TPM_C_CRC]);
	endproperty
	a_clear_only_sel: assert property (p_clear_only_sel) else $error("report cleared another link");

	// an access port write lands at its access edge
	property p_port_write;
		apb.psel && apb.penable && apb.pwrite && (apb.paddr[15:2] == `TPM_IDX_PORT) |=>
			s_q.port == {1'b0, $past(apb.pwdata[6:0])};
	endproperty
	a_port_write: assert property (p_port_write) else $error("access port write lost");
endmodule

// [rtl/tpm_pkg.sv]
// Purpose: types of the performance monitor
// Assumes: nothing
// Notes:   every link carries its own counter bank
package tpm_pkg;
	typedef enum logic [1:0] {
		TPM_FMT_SF  = 2'b00,
		TPM_FMT_ESF = 2'b01,
		TPM_FMT_DDS = 2'b10,
		TPM_FMT_SLC = 2'b11
	} tpm_fmt_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} tpm_apb_req_t;

	// one-cycle event strobes from a link's receive path
	typedef struct packed {
		logic       bpv;
		logic       b8zs_cv;
		logic       fbit_err;
		logic       crc_err;
		logic       dds_err;
		logic       pos_found;
		logic [3:0] pos;
		logic       sync_lost;
		logic       pat_err;
	} tpm_ev_t;

	typedef struct packed {
		logic [6:0][15:0] cnt;
		logic [6:0]       flag;
		logic [6:0]       en;
		logic [7:0]       ctrl;
		logic             trig_prev;
		logic [3:0]       pos;
		logic             pos_ok;
	} tpm_link_t;

	typedef struct packed {
		tpm_link_t [7:0] lk;
		logic [7:0]      port;
		logic [7:0]      data;
		logic [31:0]     prdata;
		logic            slverr;
		logic [23:0]     tick_cnt;
	} tpm_state_t;
endpackage

// [test/t1_performance_monitor_bench.sv]
// Purpose: self-checking bench of the performance monitor
// Assumes: apb answers when pready is high; shortened report period
// Notes:   counters are read through the indirect port after a report
`include "tpm_map.svh"
module t1_performance_monitor_bench;
	import tpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 50;
	logic          clock;
	logic          reset;
	logic          pready;
	logic          pslverr;
	logic          overflow_irq;
	logic          fire;
	logic          serr;
	logic [31:0]   prdata;
	logic [31:0]   rd;
	logic [2:0]    ev_link;
	tpm_apb_req_t  apb;
	tpm_ev_t       ev_req;
	tpm_ev_t [7:0] link_events;
	int            error_cnt;
	int            checks;

	tpm_monitor #(.REPORT_CYCLES(RC)) dut_u (.clock(clock), .reset(reset), .apb(apb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link_events(link_events), .overflow_irq(overflow_irq));
	tpm_rx_model rx_u (.clock(clock), .reset(reset), .fire(fire), .link(ev_link), .ev(ev_req),
		.events(link_events));

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (4000) @(posedge clock);
		error_cnt++;
		final_report();
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
		@(posedge clock);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
		@(posedge clock);
		apb.penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask
	function automatic logic [13:0] li(input logic [2:0] n, input logic [7:0] off);
		return {3'b000, n, off};
	endfunction
	task automatic ev(input logic [2:0] l, input tpm_ev_t e);
		@(posedge clock);
		fire <= 1'b1;
		ev_link <= l;
		ev_req <= e;
		@(posedge clock);
		fire <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	// trigger low then high, then fetch the data byte
	task automatic report(input logic [2:0] l, input logic [7:0] c, input logic [7:0] exp);
		bus(1'b1, li(l, `TPM_OFF_CTRL), c);
		bus(1'b1, li(l, `TPM_OFF_CTRL), c | 8'h01);
		bus(1'b0, `TPM_IDX_DATA, 8'h00);
		check(rd, {24'h0, exp});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		bus(1'b0, li(3'd0, `TPM_OFF_FLG_HI), 8'h00);
		check(rd, 32'h0);
		check({31'h0, serr}, 32'h0);
		bus(1'b0, 14'h0010, 8'h00);
		check({31'h0, serr}, 32'h1);
		check({31'h0, overflow_irq}, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_lcv();
		bus(1'b1, `TPM_IDX_PORT, 8'h08);
		for (int i = 0; i < 3; i++) ev(3'd0, tpm_ev_t'{bpv: 1'b1, default: '0});
		ev(3'd0, tpm_ev_t'{b8zs_cv: 1'b1, default: '0});
		report(3'd0, 8'h00, 8'h03);
		bus(1'b1, li(3'd0, `TPM_OFF_CTRL), 8'h10);
		for (int i = 0; i < 2; i++) ev(3'd0, tpm_ev_t'{b8zs_cv: 1'b1, default: '0});
		ev(3'd0, tpm_ev_t'{bpv: 1'b1, default: '0});
		report(3'd0, 8'h10, 8'h02);
		bus(1'b1, `TPM_IDX_PORT, 8'h09);
		report(3'd0, 8'h10, 8'h00);
		$display("test line violation done");
	endtask
	task automatic t_crc();
		bus(1'b1, `TPM_IDX_PORT, 8'h20);
		bus(1'b1, li(3'd2, `TPM_OFF_CTRL), 8'h04);
		for (int i = 0; i < 5; i++) ev(3'd2, tpm_ev_t'{crc_err: 1'b1, default: '0});
		report(3'd2, 8'h04, 8'h05);
		$display("test crc done");
	endtask
	task automatic t_fmt();
		bus(1'b1, `TPM_IDX_PORT, 8'h1a);
		bus(1'b1, li(3'd1, `TPM_OFF_CTRL), 8'h08);
		for (int i = 0; i < 2; i++) ev(3'd1, tpm_ev_t'{dds_err: 1'b1, crc_err: 1'b1, fbit_err: 1'b1, default: '0});
		report(3'd1, 8'h08, 8'h02);
		bus(1'b1, `TPM_IDX_PORT, 8'h12);
		for (int i = 0; i < 3; i++) ev(3'd1, tpm_ev_t'{fbit_err: 1'b1, pat_err: 1'b1, default: '0});
		report(3'd1, 8'h0c, 8'h03);
		ev(3'd1, tpm_ev_t'{dds_err: 1'b1, pat_err: 1'b1, default: '0});
		bus(1'b1, `TPM_IDX_PORT, 8'h1a);
		report(3'd1, 8'h0c, 8'h00);
		bus(1'b1, `TPM_IDX_PORT, 8'h16);
		ev(3'd1, tpm_ev_t'{pat_err: 1'b1, dds_err: 1'b1, default: '0});
		report(3'd1, 8'h0c, 8'h01);
		$display("test formats done");
	endtask
	task automatic t_cofa();
		bus(1'b1, `TPM_IDX_PORT, 8'h04);
		for (int i = 0; i < 10; i++) ev(3'd0, tpm_ev_t'{pos_found: 1'b1, pos: 4'(i), default: '0});
		bus(1'b0, li(3'd0, `TPM_OFF_FLG_LO), 8'h00);
		check(rd, 32'h1);
		check({31'h0, overflow_irq}, 32'h0);
		bus(1'b1, li(3'd0, `TPM_OFF_EN_LO), 8'h01);
		bus(1'b0, li(3'd0, `TPM_OFF_FLG_LO), 8'h00);
		check({31'h0, overflow_irq}, 32'h1);
		bus(1'b1, li(3'd0, `TPM_OFF_FLG_LO), 8'h01);
		bus(1'b0, li(3'd0, `TPM_OFF_FLG_LO), 8'h00);
		check(rd, 32'h0);
		check({31'h0, overflow_irq}, 32'h0);
		report(3'd0, 8'h00, 8'h07);
		$display("test alignment change done");
	endtask
	task automatic t_auto();
		bus(1'b1, `TPM_IDX_PORT, 8'h05);
		for (int i = 0; i < 2; i++) ev(3'd0, tpm_ev_t'{sync_lost: 1'b1, default: '0});
		bus(1'b1, li(3'd0, `TPM_OFF_CTRL), 8'h02);
		// poll faster than the period so the first report is caught
		for (int i = 0; i < 25 && rd !== 32'h2; i++) bus(1'b0, `TPM_IDX_DATA, 8'h00);
		check(rd, 32'h2);
		bus(1'b1, li(3'd0, `TPM_OFF_CTRL), 8'h00);
		// an event in the very cycle of a manual report opens the new round
		fork
			bus(1'b1, li(3'd0, `TPM_OFF_CTRL), 8'h01);
			begin
				repeat (2) @(posedge clock);
				fire <= 1'b1;
				ev_link <= 3'd0;
				ev_req <= tpm_ev_t'{sync_lost: 1'b1, default: '0};
				@(posedge clock);
				fire <= 1'b0;
			end
		join
		report(3'd0, 8'h00, 8'h01);
		$display("test auto report done");
	endtask

	task automatic final_report();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		apb = '0;
		fire = 1'b0;
		ev_link = 3'd0;
		ev_req = '0;
		rd = '0;
		serr = 1'b0;
		error_cnt = 0;
		checks = 0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_lcv();
		t_crc();
		t_fmt();
		t_cofa();
		t_auto();
		final_report();
	end
endmodule

// [test/tpm_rx_model.sv]
// Purpose: receive-path stand-in that strobes error events into one link
// Assumes: request inputs change just after a rising edge
// Notes:   each request gives exactly one single-cycle strobe
module tpm_rx_model
	import tpm_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          fire,
	input  wire logic [2:0]    link,
	input  wire tpm_ev_t       ev,
	output tpm_ev_t [7:0]      events
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// strobe generation
	// ----------------------------------------
	// strobes drop again after one cycle so no event is counted twice
	always_ff @(posedge clock) begin
		events <= '0;
		if (!reset && fire) begin
			events[link] <= ev;
		end
	end
endmodule
